// file: acc_far_model.sv
// far side: analog inputs of the comparator and the converter channel mux
`timescale 1ns/1ns

module acc_far_model (
    // analog levels in millivolts
    input  wire logic [11:0]      pos_mv_i,
    input  wire logic [11:0]      neg_mv_i,
    input  wire logic [11:0]      ref_mv_i,
    input  wire logic [3:0][11:0] ch_mv_i,
    // selections made by the block
    input  wire logic             power_off_i,
    input  wire logic             ref_sel_i,
    input  wire logic             mux_on_i,
    input  wire logic [1:0]       chan_i,
    // raw decision
    output logic                  cmp_raw_o
);
    logic [11:0] plus_mv;
    logic [11:0] minus_mv;

    assign plus_mv = ref_sel_i ? ref_mv_i : pos_mv_i;
    assign minus_mv = mux_on_i ? ch_mv_i[chan_i] : neg_mv_i;
    // an unpowered comparator is taken to rest low; its level is not defined
    assign cmp_raw_o = !power_off_i && (plus_mv > minus_mv);
endmodule : acc_far_model

// file: acc_pkg.sv
// package: register map, fields and types of the comparator control block
package acc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 4;
    localparam logic [3:0] OFS_CONV_B   = 4'h0;
    localparam logic [3:0] OFS_CMP_CS   = 4'h4;
    localparam logic [3:0] OFS_DIG_OFF  = 4'h8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_NEG_MUX_EN  = 6;
    localparam int BIT_POWER_OFF   = 7;
    localparam int BIT_REF_SEL     = 6;
    localparam int BIT_RESULT      = 5;
    localparam int BIT_IRQ_FLAG    = 4;
    localparam int BIT_IRQ_EN      = 3;
    localparam int BIT_POS_IN_OFF  = 0;
    localparam int BIT_NEG_IN_OFF  = 1;
    localparam int DIG_OFF_W       = 6;

    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic       RST_NEG_MUX_EN = 1'b0;
    localparam logic [5:0] RST_DIG_OFF    = 6'h00;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        EV_TOGGLE = 2'h0,
        EV_RSVD   = 2'h1,
        EV_FALL   = 2'h2,
        EV_RISE   = 2'h3
    } acc_event_e;

    typedef struct packed {
        logic       power_off;
        logic       ref_sel;
        logic       irq_en;
        acc_event_e event_sel;
    } acc_ctrl_s;

    localparam acc_ctrl_s RST_CTRL = '{1'b0, 1'b0, 1'b0, EV_TOGGLE};

endpackage : acc_pkg

// file: acc_top.sv
// top: analog comparator control, status and interrupt logic
//
// Notes on behaviour
// - result reads one when positive exceeds negative
// - result synchronised, one to two cycles late
// - event select: toggle, reserved, falling, rising
// - selected output event sets interrupt flag
// - flag clears on vector taken or write-one
// - request needs flag, local and global enable
// - disable bit switches the comparator off
// - reference select picks internal reference as positive
// - mux enable, converter off: channel drives negative
// - reserved bits read zero, writes ignored
// - input-off bit kills buffer, pin reads zero
`timescale 1ns/1ns

module acc_top (
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    // avalon-mm slave
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic      [1:0]  AVS_RESPONSE_O,
    output logic             AVS_WAITREQUEST_O,
    // analog side and pins (asynchronous)
    input  wire logic        CMP_RAW_I,
    input  wire logic        POS_PIN_I,
    input  wire logic        NEG_PIN_I,
    // core and converter side (same clock)
    input  wire logic        CONVERTER_ON_I,
    input  wire logic [1:0]  CHANNEL_SEL_I,
    input  wire logic        GLOBAL_IRQ_EN_I,
    input  wire logic        IRQ_TAKEN_I,
    // comparator control and pin outputs
    output logic             CMP_IRQ_O,
    output logic             CMP_POWER_OFF_O,
    output logic             POS_REF_SEL_O,
    output logic             NEG_MUX_ON_O,
    output logic      [1:0]  NEG_CHAN_O,
    output logic             POS_IN_OFF_O,
    output logic             NEG_IN_OFF_O,
    output logic             POS_PIN_DIG_O,
    output logic             NEG_PIN_DIG_O
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // comparator synchroniser and edge detection
    // ------------------------------------------------------------
    logic cmp_meta;
    logic cmp_res;
    logic cmp_prev;
    logic evt;
    acc_pkg::acc_ctrl_s ctrl;

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta <= 1'b0;
            cmp_res  <= 1'b0;
            cmp_prev <= 1'b0;
        end else begin
            cmp_meta <= CMP_RAW_I;
            cmp_res  <= cmp_meta;
            cmp_prev <= cmp_res;
        end
    end

    always_comb begin
        unique case (ctrl.event_sel)
            acc_pkg::EV_TOGGLE: evt = cmp_res ^ cmp_prev;
            acc_pkg::EV_FALL:   evt = cmp_prev & ~cmp_res;
            acc_pkg::EV_RISE:   evt = ~cmp_prev & cmp_res;
            acc_pkg::EV_RSVD:   evt = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    logic       req;
    logic       wr_go;
    logic       be0;
    logic [7:0] wbyte;
    logic       hit_b;
    logic       hit_cs;
    logic       hit_dig;
    logic [7:0] rd_byte;
    logic       flag;
    logic       neg_mux_en;
    logic [5:0] dig_off;

    assign req     = AVS_READ_I | AVS_WRITE_I;
    assign be0     = AVS_BYTEENABLE_I[0];
    assign wbyte   = AVS_WRITEDATA_I[7:0];
    assign hit_b   = AVS_ADDRESS_I == acc_pkg::OFS_CONV_B;
    assign hit_cs  = AVS_ADDRESS_I == acc_pkg::OFS_CMP_CS;
    assign hit_dig = AVS_ADDRESS_I == acc_pkg::OFS_DIG_OFF;
    // a write lands only at the edge that sees waitrequest low
    assign wr_go   = AVS_WRITE_I & ~AVS_WAITREQUEST_O & be0;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_b) begin
            rd_byte[acc_pkg::BIT_NEG_MUX_EN] = neg_mux_en;
        end else if (hit_cs) begin
            // bit 2 stays zero
            rd_byte = {ctrl.power_off, ctrl.ref_sel, cmp_res, flag,
                       ctrl.irq_en, 1'b0, ctrl.event_sel};
        end else if (hit_dig) begin
            rd_byte = {2'h0, dig_off};
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= 32'h0000_0000;
            AVS_RESPONSE_O    <= acc_pkg::RESP_OKAY;
        end else begin
            AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
            if (req && AVS_WAITREQUEST_O) begin
                AVS_READDATA_O <= {24'h00_0000, rd_byte};
                AVS_RESPONSE_O <= (hit_b | hit_cs | hit_dig)
                                  ? acc_pkg::RESP_OKAY
                                  : acc_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // software-written registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= acc_pkg::RST_CTRL;
        end else if (wr_go && hit_cs) begin
            // result, flag and bit 2 are not stored here
            ctrl.power_off <= wbyte[acc_pkg::BIT_POWER_OFF];
            ctrl.ref_sel   <= wbyte[acc_pkg::BIT_REF_SEL];
            ctrl.irq_en    <= wbyte[acc_pkg::BIT_IRQ_EN];
            ctrl.event_sel <= acc_pkg::acc_event_e'(wbyte[1:0]);
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            neg_mux_en <= acc_pkg::RST_NEG_MUX_EN;
            dig_off    <= acc_pkg::RST_DIG_OFF;
        end else begin
            if (wr_go && hit_b) begin
                neg_mux_en <= wbyte[acc_pkg::BIT_NEG_MUX_EN];
            end
            if (wr_go && hit_dig) begin
                dig_off <= wbyte[acc_pkg::DIG_OFF_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt flag and request
    // ------------------------------------------------------------
    logic clr_w1;

    assign clr_w1 = wr_go & hit_cs & wbyte[acc_pkg::BIT_IRQ_FLAG];

    // a new event in the clearing cycle keeps the flag set
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (evt) begin
            flag <= 1'b1;
        end else if (clr_w1 || IRQ_TAKEN_I) begin
            flag <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            CMP_IRQ_O <= 1'b0;
        end else begin
            CMP_IRQ_O <= flag & ctrl.irq_en & GLOBAL_IRQ_EN_I
                         & ~IRQ_TAKEN_I;
        end
    end

    // ------------------------------------------------------------
    // analog steering and pin buffers
    // ------------------------------------------------------------
    logic pos_meta;
    logic pos_sync;
    logic neg_meta;
    logic neg_sync;

    assign CMP_POWER_OFF_O = ctrl.power_off;
    assign POS_REF_SEL_O   = ctrl.ref_sel;
    assign POS_IN_OFF_O    = dig_off[acc_pkg::BIT_POS_IN_OFF];
    assign NEG_IN_OFF_O    = dig_off[acc_pkg::BIT_NEG_IN_OFF];

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            NEG_MUX_ON_O <= 1'b0;
            NEG_CHAN_O   <= 2'h0;
        end else begin
            NEG_MUX_ON_O <= neg_mux_en & ~CONVERTER_ON_I;
            NEG_CHAN_O   <= CHANNEL_SEL_I;
        end
    end

    // off pins read zero; the sync chain still runs, costing nothing
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            pos_meta      <= 1'b0;
            pos_sync      <= 1'b0;
            neg_meta      <= 1'b0;
            neg_sync      <= 1'b0;
            POS_PIN_DIG_O <= 1'b0;
            NEG_PIN_DIG_O <= 1'b0;
        end else begin
            pos_meta      <= POS_PIN_I;
            pos_sync      <= pos_meta;
            neg_meta      <= NEG_PIN_I;
            neg_sync      <= neg_meta;
            POS_PIN_DIG_O <= pos_sync & ~POS_IN_OFF_O;
            NEG_PIN_DIG_O <= neg_sync & ~NEG_IN_OFF_O;
        end
    end

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!rst_n);

    chk_result_sync: assert property (
        $past(rst_n, 3) |-> cmp_res == $past(CMP_RAW_I, 2))
        else $error("result not two cycles behind comparator");

    chk_prev_sample: assert property (
        $past(rst_n) |-> cmp_prev == $past(cmp_res))
        else $error("previous sample not kept");

    chk_event_sets: assert property (
        evt |=> flag)
        else $error("event did not set flag");

    chk_rise_mode: assert property (
        ctrl.event_sel == acc_pkg::EV_RISE && cmp_prev && !cmp_res
        |-> !evt)
        else $error("falling edge seen in rising mode");

    chk_rsvd_mode: assert property (
        ctrl.event_sel == acc_pkg::EV_RSVD |-> !evt)
        else $error("reserved mode raised an event");

    chk_flag_taken: assert property (
        IRQ_TAKEN_I && !evt |=> !flag)
        else $error("flag not cleared on vector");

    chk_write_zero: assert property (
        wr_go && hit_cs && !wbyte[acc_pkg::BIT_IRQ_FLAG] && flag
        && !IRQ_TAKEN_I |=> flag)
        else $error("writing zero cleared the flag");

    chk_irq_gate: assert property (
        CMP_IRQ_O |-> $past(flag && ctrl.irq_en && GLOBAL_IRQ_EN_I))
        else $error("request without flag and enables");

    chk_power_bit: assert property (
        wr_go && hit_cs
        |=> CMP_POWER_OFF_O == $past(AVS_WRITEDATA_I[acc_pkg::BIT_POWER_OFF]))
        else $error("disable bit not stored");

    chk_neg_route: assert property (
        neg_mux_en && CONVERTER_ON_I |=> !NEG_MUX_ON_O)
        else $error("mux used while converter on");

    chk_rsvd_zero: assert property (
        AVS_READ_I && AVS_WAITREQUEST_O && hit_cs
        |=> AVS_READDATA_O[2] == 1'b0 && AVS_READDATA_O[31:8] == 24'h0)
        else $error("reserved bits read non-zero");

    chk_pin_zero: assert property (
        POS_IN_OFF_O ##1 POS_IN_OFF_O |-> !POS_PIN_DIG_O)
        else $error("disabled pin reads one");

    cov_rise_irq:   cover property (
        ctrl.event_sel == acc_pkg::EV_RISE && evt ##1 CMP_IRQ_O);
    cov_fall_event: cover property (
        ctrl.event_sel == acc_pkg::EV_FALL && evt);
    cov_toggle_set: cover property (
        ctrl.event_sel == acc_pkg::EV_TOGGLE && evt && clr_w1);
    cov_bus_read:   cover property (
        AVS_READ_I && !AVS_WAITREQUEST_O && hit_cs);

endmodule : acc_top

// file: analog_comparator_ctrl_test.sv
// bench: directed scenarios for the comparator control block
`timescale 1ns/1ns

module analog_comparator_ctrl_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [3:0] CV = acc_pkg::OFS_CONV_B;
    localparam logic [3:0] CS = acc_pkg::OFS_CMP_CS;
    localparam logic [3:0] DG = acc_pkg::OFS_DIG_OFF;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [1:0] resp, chsel = 2'h0, chan, r;
    logic wt, raw, irq, pwr, rsel, mux, poff, noff, pdig, ndig;
    logic ppin = 1'b0, npin = 1'b0, conv = 1'b0, glob = 1'b0, tkn = 1'b0;
    logic [11:0] pos_mv = 12'h000, neg_mv = 12'h1f4, ref_mv = 12'h000;
    logic [3:0][11:0] ch_mv = {4{12'h384}};
    int err_total = 0, samples_checked = 0, cycles = 0;

    always #50 clk = ~clk;

    acc_top DUT (
        .CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
        .AVS_RESPONSE_O(resp), .AVS_WAITREQUEST_O(wt),
        .CMP_RAW_I(raw), .POS_PIN_I(ppin), .NEG_PIN_I(npin),
        .CONVERTER_ON_I(conv), .CHANNEL_SEL_I(chsel),
        .GLOBAL_IRQ_EN_I(glob), .IRQ_TAKEN_I(tkn), .CMP_IRQ_O(irq),
        .CMP_POWER_OFF_O(pwr), .POS_REF_SEL_O(rsel), .NEG_MUX_ON_O(mux),
        .NEG_CHAN_O(chan), .POS_IN_OFF_O(poff), .NEG_IN_OFF_O(noff),
        .POS_PIN_DIG_O(pdig), .NEG_PIN_DIG_O(ndig)
    );
    acc_far_model far (
        .pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .ref_mv_i(ref_mv),
        .ch_mv_i(ch_mv), .power_off_i(pwr), .ref_sel_i(rsel),
        .mux_on_i(mux), .chan_i(chan), .cmp_raw_o(raw)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // request held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        r = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [7:0] e, string n);
        bus(1'b0, a, 8'h00);
        chk(n, q, {24'h0, e});
        chk("response", {30'h0, r}, {30'h0, acc_pkg::RESP_OKAY});
    endtask : rreg

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rreg(CV, 8'h00, "conv reset");
        rreg(CS, 8'h00, "ctrl reset");
        rreg(DG, 8'h00, "dig reset");
        wreg(CV, 8'hff);
        rreg(CV, 8'h40, "conv rw");
        wreg(DG, 8'hff);
        rreg(DG, 8'h3f, "dig rw");
        wreg(CS, 8'hc7);  // enable stays low across the change
        rreg(CS, 8'hc3, "ctrl rw");
        chk("power off", {31'h0, pwr}, 32'h1);
        chk("ref sel", {31'h0, rsel}, 32'h1);
        wreg(CS, 8'h00);
        wreg(CV, 8'h00);
        wreg(DG, 8'h00);
        // a write with byte lane 0 off must leave the register alone
        be <= 4'h0;
        wreg(CV, 8'hff);
        be <= 4'h1;
        rreg(CV, 8'h00, "lane off");
        bus(1'b0, 4'hc, 8'h00);
        chk("unmapped data", q, 32'h0);
        chk("unmapped resp", {30'h0, r}, {30'h0, acc_pkg::RESP_SLVERR});
        $display("regs done");
    endtask : t_regs

    task automatic t_events;
        for (int s = 0; s < 4; s++) begin
            wreg(CS, 8'h10 | s[7:0]);  // enable low while mode changes
            pos_mv <= 12'h384;
            repeat (5) @(posedge clk);
            rreg(CS, {2'b00, 1'b1, s == 0 || s == 3, 2'b00, s[1:0]},
                 "rise");
            wreg(CS, 8'h10 | s[7:0]);
            pos_mv <= 12'h000;
            repeat (5) @(posedge clk);
            rreg(CS, {3'b000, s == 0 || s == 2, 2'b00, s[1:0]},
                 "fall");
        end
        $display("events done");
    endtask : t_events

    task automatic t_irq;
        wreg(CS, 8'h13);
        wreg(CS, 8'h0b);
        pos_mv <= 12'h384;
        repeat (5) @(posedge clk);
        chk("irq no global", {31'h0, irq}, 32'h0);
        glob <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        tkn <= 1'b1;
        @(posedge clk);
        tkn <= 1'b0;
        @(posedge clk);
        chk("irq taken", {31'h0, irq}, 32'h0);
        rreg(CS, 8'h2b, "flag taken");
        pos_mv <= 12'h000;
        repeat (3) @(posedge clk);
        pos_mv <= 12'h384;
        repeat (5) @(posedge clk);
        wreg(CS, 8'h0b);
        rreg(CS, 8'h3b, "flag write zero");
        chk("irq kept", {31'h0, irq}, 32'h1);
        wreg(CS, 8'h03);
        repeat (2) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wreg(CS, 8'h13);
        rreg(CS, 8'h23, "flag write one");
        glob <= 1'b0;
        pos_mv <= 12'h000;
        $display("irq done");
    endtask : t_irq

    task automatic t_mux;
        wreg(CV, 8'h40);
        pos_mv <= 12'h1f4;
        neg_mv <= 12'h000;
        for (int k = 0; k < 8; k++) begin
            conv <= k[2];
            chsel <= k[1:0];
            for (int j = 0; j < 4; j++)
                ch_mv[j] <= (j == k % 4) ? 12'h384 : 12'h064;
            repeat (5) @(posedge clk);
            chk("mux on", {31'h0, mux}, {31'h0, !k[2]});
            chk("mux chan", {30'h0, chan}, {30'h0, k[1:0]});
            wreg(CS, 8'h13);
            rreg(CS, {2'b00, k[2], 5'h03}, "neg input");
        end
        conv <= 1'b0;
        wreg(CV, 8'h00);
        wreg(CS, 8'h43);
        repeat (5) @(posedge clk);
        // the mux hand-over above makes a real rising edge: clear it
        wreg(CS, 8'h53);
        rreg(CS, 8'h43, "ref low");
        wreg(CS, 8'h13);
        repeat (5) @(posedge clk);
        rreg(CS, 8'h33, "pin high");
        $display("mux done");
    endtask : t_mux

    task automatic t_pins;
        ppin <= 1'b1;
        npin <= 1'b1;
        wreg(DG, 8'h01);  // analog-only pin buffer off
        repeat (4) @(posedge clk);
        chk("pos dig", {30'h0, pdig, ndig}, 32'h1);
        chk("off bits", {30'h0, noff, poff}, 32'h1);
        wreg(DG, 8'h02);
        repeat (4) @(posedge clk);
        chk("neg dig", {30'h0, pdig, ndig}, 32'h2);
        $display("pins done");
    endtask : t_pins

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_events();
        t_irq();
        t_mux();
        t_pins();
        print_verdict();
    end
endmodule : analog_comparator_ctrl_test
